/* File: pkg/sem_host_pkg.sv */
// Constants for the host-side semaphore and contention controller
package sem_host_pkg;
  localparam int ADDR_W_DEF  = 13;   // Port address width
  localparam int DATA_W_DEF  = 18;   // Port data width
  localparam int SEM_CNT     = 8;    // Number of semaphore latches
  localparam int SEM_IDX_W   = 3;    // Semaphore index bits (lowest address bits)
  localparam int OP_W        = 2;    // User command width
  localparam logic [1:0] OP_CLAIM   = 2'h0;  // Write zero, then read back
  localparam logic [1:0] OP_RELEASE = 2'h1;  // Write one
  localparam logic [1:0] OP_POLL    = 2'h2;  // Read only
  localparam logic [1:0] OP_INIT    = 2'h3;  // Write one to every latch
  // Setup time from address/enable valid to write strobe, in ns
  localparam int SETUP_NS     = 40;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETUP_CYC    = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe pulse and readback timing, in ns
  localparam int PULSE_NS     = 24;
  localparam int PULSE_CYC    = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W        = 4;   // Width of the phase timer
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRITE = 3'b011,
    ST_GAP   = 3'b010,
    ST_READ  = 3'b110,
    ST_DONE  = 3'b111
  } host_state_e;
endpackage : sem_host_pkg

/* File: rtl/sem_host_ctrl.sv */
// Host controller driving one port's semaphore and contention pins of the shared memory
`timescale 1ns/1ps
module sem_host_ctrl
  import sem_host_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,   // Device address width
  parameter int DATA_W = DATA_W_DEF    // Device data width
)(
  input  wire logic                 SYS_CLK_IN,      // System clock
  input  wire logic                 RESET_IN,        // Async reset, active high
  input  wire logic                 CLK_EN_IN,       // Freezes all state when low
  input  wire logic                 CMD_VALID_IN,    // Command request
  input  wire logic [OP_W-1:0]      CMD_OP_IN,       // Command code
  input  wire logic [SEM_IDX_W-1:0] CMD_SEM_IN,      // Target latch
  input  wire logic                 BUSY_N_IN,       // Contention pin from master device
  input  wire logic [DATA_W-1:0]    DQ_IN,           // Data pins, device to host
  output logic                      CMD_READY_OUT,   // Ready for a command
  output logic                      DONE_OUT,        // One-cycle completion pulse
  output logic                      GRANTED_OUT,     // Readback showed ownership
  output logic                      CONTENDED_OUT,   // Contention seen during the write strobe
  output logic                      CE_N_OUT,        // Memory chip enable, kept high
  output logic                      SEM_SEL_N_OUT,   // semaphore_select_n pin
  output logic                      OE_N_OUT,        // Output enable
  output logic                      RW_N_OUT,        // Read high, write low
  output logic [ADDR_W-1:0]         ADDR_OUT,        // Address pins
  output logic [DATA_W-1:0]         DQ_OUT,          // Data pins, host to device
  output logic                      DQ_OE_OUT        // High while host drives data
);

  initial
  begin
    // Upper address bits and upper data bits must both exist for the pin checks below
    if (ADDR_W <= SEM_IDX_W || DATA_W < 2)
      $error("sem_host_ctrl: address or data width too small");
  end

  // All-zeros check of a semaphore readback
  function automatic logic flag_held(input logic [DATA_W-1:0] d);
    flag_held = (d == '0);
  endfunction : flag_held

  host_state_e            state_reg, state_next;     // Sequencer state
  logic [CNT_W-1:0]       cnt_reg, cnt_next;         // Phase timer
  logic [OP_W-1:0]        op_reg, op_next;           // Active command
  logic [SEM_IDX_W-1:0]   idx_reg, idx_next;         // Active latch index
  logic                   ready_reg, ready_next;
  logic                   done_reg, done_next;
  logic                   grant_reg, grant_next;
  logic                   cont_reg, cont_next;
  logic                   sem_reg, sem_next;
  logic                   oe_reg, oe_next;
  logic                   rw_reg, rw_next;
  logic [ADDR_W-1:0]      addr_reg, addr_next;
  logic [DATA_W-1:0]      dq_reg, dq_next;
  logic                   dqoe_reg, dqoe_next;

  // Sequencer: setup, write strobe, gap, readback
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    op_next    = op_reg;
    idx_next   = idx_reg;
    ready_next = ready_reg;
    done_next  = 1'b0;
    grant_next = grant_reg;
    cont_next  = cont_reg;
    sem_next   = sem_reg;
    oe_next    = oe_reg;
    rw_next    = rw_reg;
    addr_next  = addr_reg;
    dq_next    = dq_reg;
    dqoe_next  = dqoe_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (CMD_VALID_IN && ready_reg)
        begin
          // Address and select go out first; write waits for contention to settle
          op_next    = CMD_OP_IN;
          idx_next   = (CMD_OP_IN == OP_INIT) ? '0 : CMD_SEM_IN;
          addr_next  = '0;
          addr_next[SEM_IDX_W-1:0] = (CMD_OP_IN == OP_INIT) ? '0 : CMD_SEM_IN;
          sem_next   = 1'b0;
          ready_next = 1'b0;
          cont_next  = 1'b0;
          cnt_next   = CNT_W'(SETUP_CYC);
          state_next = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (cnt_reg > CNT_W'(1))
          cnt_next = cnt_reg - CNT_W'(1);
        else if (op_reg == OP_POLL)
        begin
          oe_next    = 1'b0;
          cnt_next   = CNT_W'(PULSE_CYC);
          state_next = ST_READ;
        end
        else
        begin
          // Claim writes zero, release and init write one, on bit zero only
          rw_next    = 1'b0;
          dqoe_next  = 1'b1;
          dq_next    = '0;
          dq_next[0] = (op_reg != OP_CLAIM);
          cnt_next   = CNT_W'(PULSE_CYC);
          state_next = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        // One contention line only: a single master decides for the whole word
        if (!BUSY_N_IN)
          cont_next = 1'b1;
        if (cnt_reg > CNT_W'(1))
          cnt_next = cnt_reg - CNT_W'(1);
        else
        begin
          rw_next    = 1'b1;
          dqoe_next  = 1'b0;
          sem_next   = 1'b1;           // Select drops so the next read latches afresh
          state_next = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (op_reg == OP_CLAIM)
        begin
          sem_next   = 1'b0;
          oe_next    = 1'b0;
          cnt_next   = CNT_W'(PULSE_CYC);
          state_next = ST_READ;
        end
        else if (op_reg == OP_INIT && idx_reg != SEM_IDX_W'(SEM_CNT - 1))
        begin
          // Walk all latches so every one starts free
          idx_next   = idx_reg + SEM_IDX_W'(1);
          addr_next[SEM_IDX_W-1:0] = idx_reg + SEM_IDX_W'(1);
          sem_next   = 1'b0;
          cnt_next   = CNT_W'(SETUP_CYC);
          state_next = ST_SETUP;
        end
        else
        begin
          grant_next = 1'b0;
          state_next = ST_DONE;
        end
      end
      ST_READ:
      begin
        if (cnt_reg > CNT_W'(1))
          cnt_next = cnt_reg - CNT_W'(1);
        else
        begin
          grant_next = flag_held(DQ_IN);
          oe_next    = 1'b1;
          sem_next   = 1'b1;
          state_next = ST_DONE;
        end
      end
      ST_DONE:
      begin
        done_next  = 1'b1;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // Registers; clock enable freezes everything
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      op_reg    <= OP_CLAIM;
      idx_reg   <= '0;
      ready_reg <= 1'b1;
      done_reg  <= 1'b0;
      grant_reg <= 1'b0;
      cont_reg  <= 1'b0;
      sem_reg   <= 1'b1;
      oe_reg    <= 1'b1;
      rw_reg    <= 1'b1;
      addr_reg  <= '0;
      dq_reg    <= '0;
      dqoe_reg  <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      op_reg    <= op_next;
      idx_reg   <= idx_next;
      ready_reg <= ready_next;
      done_reg  <= done_next;
      grant_reg <= grant_next;
      cont_reg  <= cont_next;
      sem_reg   <= sem_next;
      oe_reg    <= oe_next;
      rw_reg    <= rw_next;
      addr_reg  <= addr_next;
      dq_reg    <= dq_next;
      dqoe_reg  <= dqoe_next;
    end
  end

  assign CMD_READY_OUT = ready_reg;
  assign DONE_OUT      = done_reg;
  assign GRANTED_OUT   = grant_reg;
  assign CONTENDED_OUT = cont_reg;
  assign CE_N_OUT      = 1'b1;      // Memory array never selected with semaphores
  assign SEM_SEL_N_OUT = sem_reg;
  assign OE_N_OUT      = oe_reg;
  assign RW_N_OUT      = rw_reg;
  assign ADDR_OUT      = addr_reg;
  assign DQ_OUT        = dq_reg;
  assign DQ_OE_OUT     = dqoe_reg;

  // Write strobe only after the setup phase
  sequence setup_then_write;
    $fell(rw_reg) ##0 !sem_reg;
  endsequence

  chk_write_after_setup: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $fell(rw_reg) |-> $past(state_reg) == ST_SETUP)
    else $error("write strobe without setup");
  chk_write_bit_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    setup_then_write |-> dq_reg[DATA_W-1:1] == '0)
    else $error("upper data bits driven on semaphore write");
  chk_claim_writes_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    setup_then_write |-> dq_reg[0] == (op_reg != OP_CLAIM))
    else $error("wrong semaphore write value");
  chk_sem_select_low: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (!rw_reg || !oe_reg) |-> !sem_reg)
    else $error("access without semaphore select");
  chk_high_addr_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    !sem_reg |-> addr_reg[ADDR_W-1:SEM_IDX_W] == '0)
    else $error("upper address bits set");
  chk_poll_gap: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $rose(oe_reg) |-> sem_reg)
    else $error("select held across reads");
  chk_claim_reads_back: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (state_reg == ST_GAP && op_reg == OP_CLAIM && CLK_EN_IN) |=> state_reg == ST_READ)
    else $error("claim without readback");
  chk_init_all_free: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (state_reg == ST_DONE && op_reg == OP_INIT) |-> idx_reg == SEM_IDX_W'(SEM_CNT - 1))
    else $error("init stopped early");

endmodule : sem_host_ctrl

/* File: tb/sem_dev_model.sv */
// Behavioural model of the shared memory's semaphore port, host side left
`timescale 1ns/1ps
module sem_dev_model
  import sem_host_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,  // Address width
  parameter int DATA_W = DATA_W_DEF   // Data width
)(
  input  wire logic              sem_n_in,    // Host semaphore_select_n
  input  wire logic              oe_n_in,     // Host output enable
  input  wire logic              rw_n_in,     // Host read/write
  input  wire logic [ADDR_W-1:0] addr_in,     // Host address
  input  wire logic [DATA_W-1:0] dq_in,       // Host write data
  input  wire logic              busy_n_in,   // Write inhibit from master
  input  wire logic              r_wr_in,     // Far-side write pulse
  input  wire logic              r_val_in,    // Far-side write value
  input  wire logic [2:0]        r_idx_in,    // Far-side latch index
  output logic [DATA_W-1:0]      dq_out,      // Data back to host
  output logic [SEM_CNT-1:0]     r_flag_out   // Far-side view of flags
);
  logic [1:0]         own_reg [SEM_CNT];  // Owner: 0 free, 1 host, 2 far
  logic [SEM_CNT-1:0] req_h_reg;          // Host request latches, low pending
  logic [SEM_CNT-1:0] req_r_reg;          // Far request latches
  logic               rd_act;             // Host semaphore read active
  logic               wr_act;             // Host semaphore write strobe
  assign rd_act = !sem_n_in && !oe_n_in;
  assign wr_act = !sem_n_in && !rw_n_in;
  // Not cleared at power up: host seems to hold every token
  initial
  begin
    for (int i = 0; i < SEM_CNT; i++) own_reg[i] = 2'h1;
    req_h_reg = '0;
    req_r_reg = '1;
    dq_out = '0;
  end
  // One write from side s; flags gate nothing else in the model
  task automatic put(input int s, input int i, input logic v);
    if (s == 1) req_h_reg[i] = v; else req_r_reg[i] = v;
    if (!v && own_reg[i] == 2'h0) own_reg[i] = 2'(s);
    if (v && own_reg[i] == 2'(s))
    begin
      own_reg[i] = ((s == 1) ? !req_r_reg[i] : !req_h_reg[i]) ? 2'(3 - s) : 2'h0;
    end
  endtask : put
  // Sample just after the strobe starts so data has settled; busy low inhibits
  always @(posedge wr_act)
  begin
    #1;
    if (busy_n_in) put(1, int'(addr_in[2:0]), dq_in[0]);
  end
  always @(posedge r_wr_in) put(2, int'(r_idx_in), r_val_in);
  // Value latched when select and enable go active, spread on all bits
  always @(posedge rd_act) dq_out = {DATA_W{own_reg[addr_in[2:0]] != 2'h1}};
  // Released bus shows the inverse, never a stale value
  always @(negedge rd_act) dq_out = ~dq_out;
  always_comb
  begin
    for (int i = 0; i < SEM_CNT; i++) r_flag_out[i] = own_reg[i] != 2'h2;
  end
endmodule : sem_dev_model

/* File: tb/sem_host_ctrl_tb.sv */
// Self-checking testbench for the semaphore host controller
`timescale 1ns/1ps
module sem_host_ctrl_tb;
  import sem_host_pkg::*;
  localparam int AW = ADDR_W_DEF;    // Address width
  localparam int DW = DATA_W_DEF;    // Data width
  logic          sys_clk = 1'b0;     // 125 MHz clock
  logic          reset = 1'b1;       // Active high reset
  logic          clk_en = 1'b1;      // Clock enable
  logic          cmd_valid = 1'b0;   // Command strobe
  logic [1:0]    cmd_op = 2'h0;      // Command code
  logic [2:0]    cmd_sem = 3'h0;     // Latch index
  logic          busy_n = 1'b1;      // Contention idle: no address match
  logic          r_wr = 1'b0;        // Far-side write pulse
  logic          r_val = 1'b1;       // Far-side value
  logic [2:0]    r_idx = 3'h0;       // Far-side index
  logic [DW-1:0] dq_dev, dq_host;    // Data both ways
  logic [AW-1:0] addr;               // Address pins
  logic [7:0]    r_flag;             // Far view of flags
  logic ready, done, granted, contended, ce_n, sem_n, oe_n, rw_n, dq_oe, rw_q;
  int            err_count = 0;      // Mismatches
  int            samples_checked = 0; // Comparisons
  int            setup_n = 0;        // Cycles select has been low
  always #4 sys_clk = ~sys_clk;
  sem_host_ctrl dut (.SYS_CLK_IN(sys_clk), .RESET_IN(reset), .CLK_EN_IN(clk_en),
    .CMD_VALID_IN(cmd_valid), .CMD_OP_IN(cmd_op), .CMD_SEM_IN(cmd_sem), .BUSY_N_IN(busy_n),
    .DQ_IN(dq_dev), .CMD_READY_OUT(ready), .DONE_OUT(done), .GRANTED_OUT(granted),
    .CONTENDED_OUT(contended), .CE_N_OUT(ce_n), .SEM_SEL_N_OUT(sem_n), .OE_N_OUT(oe_n),
    .RW_N_OUT(rw_n), .ADDR_OUT(addr), .DQ_OUT(dq_host), .DQ_OE_OUT(dq_oe));
  sem_dev_model model (.sem_n_in(sem_n), .oe_n_in(oe_n), .rw_n_in(rw_n), .addr_in(addr),
    .dq_in(dq_host), .busy_n_in(busy_n), .r_wr_in(r_wr), .r_val_in(r_val),
    .r_idx_in(r_idx), .dq_out(dq_dev), .r_flag_out(r_flag));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // Drive n clocks later plus a fixed skew
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // Issue one command, wait bounded for completion, check results
  task automatic cmd(input logic [1:0] op, input logic [2:0] i, input logic g, input logic c);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    cmd_op = op;
    cmd_sem = i;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    // A run-out limit counts as a mismatch and ends the run at once
    if (n >= 400)
    begin
      err_count++;
      finish_test();
    end
    else
    begin
      check("granted", granted, g);
      check("contended", contended, c);
    end
  endtask : cmd
  // Far-side processor writes one latch
  task automatic far_wr(input logic [2:0] i, input logic v);
    r_idx = i;
    r_val = v;
    r_wr = 1'b1;
    tick(1);
    r_wr = 1'b0;
    tick(1);
  endtask : far_wr
  // Pin watch while the host selects the semaphore space
  always @(posedge sys_clk)
  begin
    if (!reset && !sem_n)
    begin
      check("chip enable", ce_n, 1);
      check("addr high bits", addr[AW-1:SEM_IDX_W], 0);
      if (!rw_n) check("data high bits", dq_host[DW-1:1], 0);
      check("data enable", dq_oe, !rw_n);
      if (!rw_n && rw_q) check("setup", setup_n >= SETUP_CYC, 1);
    end
    setup_n = sem_n ? 0 : setup_n + 1;
    rw_q = rw_n;
  end
  initial
  begin
    tick(20);
    reset = 1'b0;
    check("idle pins", {ready, sem_n, oe_n, rw_n, ce_n, dq_oe, done}, 7'h7C);
    cmd(OP_INIT, 3'h0, 1'b0, 1'b0);
    check("far flags", r_flag, 8'hFF);
    // Far side takes a latch only if init dropped the host's stale requests
    for (int i = 0; i < SEM_CNT; i++)
    begin
      far_wr(3'(i), 1'b0);
      check("far takes", r_flag[i], 0);
      far_wr(3'(i), 1'b1);
      check("far frees", r_flag[i], 1);
    end
    for (int i = 0; i < SEM_CNT; i++)
    begin
      cmd(OP_CLAIM, 3'(i), 1'b1, 1'b0);
      far_wr(3'(i), 1'b0);
      cmd(OP_POLL, 3'(i), 1'b1, 1'b0);
      cmd(OP_RELEASE, 3'(i), 1'b0, 1'b0);
      check("far owns", r_flag[i], 0);
      cmd(OP_CLAIM, 3'(i), 1'b0, 1'b0);
      far_wr(3'(i), 1'b1);
      cmd(OP_POLL, 3'(i), 1'b1, 1'b0);
      cmd(OP_RELEASE, 3'(i), 1'b0, 1'b0);
      check("far free", r_flag[i], 1);
    end
    busy_n = 1'b0;
    cmd(OP_CLAIM, 3'h5, 1'b0, 1'b1);
    busy_n = 1'b1;
    cmd(OP_POLL, 3'h5, 1'b0, 1'b0);
    fork
      cmd(OP_CLAIM, 3'h2, 1'b1, 1'b0);
      begin tick(6); clk_en = 1'b0; tick(15); clk_en = 1'b1; end
    join
    cmd(OP_RELEASE, 3'h2, 1'b0, 1'b0);
    finish_test();
  end
endmodule : sem_host_ctrl_tb
